// [design/ccs_defs.vh]
// constants of the core context shadow bank
// Contract
// (RQ1) flag copy at 0x1FE4, bits 4..0
// (RQ2) expiry flag: set kick/sleep, clear timeout
// (RQ3) sleep flag: set by kick, cleared sleep
// (RQ4) null flag follows zero result
// (RQ5) nibble flag is carry from bit 3
// (RQ6) msb flag is carry from bit 7
// (RQ7) subtract adds complement; carries mean borrow; here a carry of one means no borrow
// (RQ8) rotate loads msb flag with shifted bit
// (RQ9) copies unreset at power-on, kept otherwise
// (RQ10) working value copy at 0x1FE5, 8 bits
// (RQ11) bank select copy 0x1FE6, bits 5..0
// (RQ12) upper pc copy 0x1FE7, bits 6..0
// (RQ13) pointer copies at 0x1FE8 and 0x1FEA
// (RQ14) pointer copies split low/high byte addresses
// (RQ15) config table 8200h-821Fh, never writable
// (RQ16) table returns fixed size constants
// (RQ17) capture on interrupt entry, restore on return
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

// data addresses of the copies
`define CCS_FLAGS_ADDR      16'h1FE4
`define CCS_WORK_ADDR       16'h1FE5
`define CCS_BANK_ADDR       16'h1FE6
`define CCS_PCLATCH_ADDR    16'h1FE7
`define CCS_PTR0_LO_ADDR    16'h1FE8
`define CCS_PTR0_HI_ADDR    16'h1FE9
`define CCS_PTR1_LO_ADDR    16'h1FEA
`define CCS_PTR1_HI_ADDR    16'h1FEB

// flag bit positions
`define CCS_EXPIRY_BIT      4
`define CCS_SLEEP_BIT       3
`define CCS_NULL_BIT        2
`define CCS_NIBBLE_BIT      1
`define CCS_MSB_BIT         0

// reset value of control state
`define CCS_RD_RESET        8'h00

// config table window and contents
`define CCS_CFG_BASE        16'h8200
`define CCS_CFG_LAST        16'h821F
`define CCS_CFG_ERASE_ROW   5'h00
`define CCS_CFG_WR_LATCH    5'h01
`define CCS_CFG_USER_ROWS   5'h02
`define CCS_CFG_EE_BYTES    5'h03
`define CCS_CFG_PINS        5'h04
`define CCS_ERASE_ROW_WORDS 14'h0020
`define CCS_WRITE_LATCHES   14'h0020
`define CCS_USER_ROWS       14'h0200
`define CCS_EEPROM_BYTES    14'h0100

// operation codes of the flag unit
`define CCS_OP_ADD          3'h0
`define CCS_OP_SUB          3'h1
`define CCS_OP_RLC          3'h2
`define CCS_OP_RRC          3'h3
`define CCS_OP_LOGIC        3'h4

`endif

// [design/ccs_bank.v]
// core context shadow bank with flag unit and config table
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ccs_defs.vh"

module ccs_bank #(
  parameter [13:0] PIN_COUNT = 14'h0014  // package pin total, 14/16/20
) (
  // clock and resets
  input  wire        clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire        soft_rst,
  // software register port
  input  wire [15:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output wire [7:0]  bus_rdata,
  // config table read port
  input  wire [15:0] cfg_addr,
  input  wire        cfg_rd,
  output wire [13:0] cfg_rdata,
  // primary context from the core
  input  wire        isr_entry,
  input  wire        isr_return,
  input  wire [4:0]  core_flags,
  input  wire [7:0]  core_work,
  input  wire [5:0]  core_bank,
  input  wire [6:0]  core_pclatch,
  input  wire [15:0] core_ptr0,
  input  wire [15:0] core_ptr1,
  // restore values back to the core
  output wire        restore_strobe,
  output wire [4:0]  restore_flags,
  output wire [7:0]  restore_work,
  output wire [5:0]  restore_bank,
  output wire [6:0]  restore_pclatch,
  output wire [15:0] restore_ptr0,
  output wire [15:0] restore_ptr1,
  // instruction events on the flag copy
  input  wire        watchdog_kick_instr,
  input  wire        sleep_instr,
  input  wire        watchdog_timeout,
  input  wire        alu_upd,
  input  wire [2:0]  alu_op,
  input  wire [7:0]  alu_a,
  input  wire [7:0]  alu_b,
  output wire [7:0]  alu_result
);

  // how this bank behaves, in short:
  // the copies keep the core context across an interrupt; they have no
  // reset, so power-on leaves them unknown and soft_rst leaves them alone
  // priority in one enabled cycle, lowest first: software write, flag
  // unit update, watchdog time-out clear, kick or sleep set, capture
  // capture on isr_entry overwrites every copy at once, so a software
  // write in the same cycle is lost; firmware must not race the core
  // expiry and sleep bits are read-only on the register port; only the
  // instruction events and a capture move them
  // the flag unit is one nine-bit adder shared by add and subtract;
  // subtract feeds the inverted operand plus a carry in, so a carry of
  // one means no borrow and callers must read it that way
  // rotates route the old msb flag through the result and leave the
  // null and nibble flags alone
  // a logic operation only updates the null flag; its result is formed
  // in the core and handed in on alu_a
  // the config table is pure decode logic behind a read-data flop, so
  // there is no path at all that could change its contents
  // read data is one cycle late and zero in every other enabled cycle, which
  // lets the core or several read ports together without a mux
  // clk_en low freezes every flop here, the read pipeline included
  // the restore outputs are the copies themselves; restore_strobe only
  // tells the core when to take them back
  // trade-off: no reset on the copies saves area and matches the
  // power-on behaviour, but simulation shows unknowns until the first
  // capture or write, so tests must load the copies before checking
  // unknown flag-unit codes update alu_result with alu_a and leave every
  // flag alone, so a bad opcode can never corrupt the context

  // shadow storage, deliberately without reset
  reg  [4:0]  flags_copy_reg;         // expiry, sleep, null, nibble, msb
  reg  [7:0]  working_value_copy_reg; // full byte
  reg  [5:0]  bank_select_copy_reg;   // six bank bits
  reg  [6:0]  upper_pc_latch_copy_reg;// seven upper pc bits
  reg  [15:0] indirect_pointer0_copy_reg;
  reg  [15:0] indirect_pointer1_copy_reg;
  reg  [7:0]  alu_result_reg;         // last flag-unit result

  // control state, reset by arst_n
  reg  [7:0]  rd_data_reg;            // read data, one cycle late
  reg  [7:0]  rd_data_next;           // read mux output
  reg  [13:0] cfg_data_reg;           // config table read data
  reg  [13:0] cfg_data_next;          // config table lookup
  reg         restore_reg;            // return-from-interrupt pulse

  // flag unit wires
  reg  [7:0]  alu_b_eff;              // second operand after complement
  reg         alu_cin;                // carry into bit 0
  reg  [8:0]  alu_sum;                // nine-bit sum
  reg  [4:0]  alu_nib;                // low nibble sum
  reg  [7:0]  alu_res_next;           // result of the operation
  reg         null_next;              // zero-result flag value
  reg         nibble_next;            // nibble carry value
  reg         msb_next;               // msb carry or rotated bit
  reg         null_upd;               // null flag touched
  reg         carry_upd;              // nibble flag touched
  reg         msb_upd;                // msb flag touched

  // write decodes; the full address is compared so nothing aliases
  // into the copies from the rest of the data space, at the cost of
  // a wide comparator per register
  wire wr_flags = bus_wr & (bus_addr == `CCS_FLAGS_ADDR);
  wire wr_work  = bus_wr & (bus_addr == `CCS_WORK_ADDR);
  wire wr_bank  = bus_wr & (bus_addr == `CCS_BANK_ADDR);
  wire wr_pcl   = bus_wr & (bus_addr == `CCS_PCLATCH_ADDR);
  wire wr_p0lo  = bus_wr & (bus_addr == `CCS_PTR0_LO_ADDR);
  wire wr_p0hi  = bus_wr & (bus_addr == `CCS_PTR0_HI_ADDR);
  wire wr_p1lo  = bus_wr & (bus_addr == `CCS_PTR1_LO_ADDR);
  wire wr_p1hi  = bus_wr & (bus_addr == `CCS_PTR1_HI_ADDR);

  // config table offset within its window
  wire        cfg_hit = (cfg_addr >= `CCS_CFG_BASE) &&
                        (cfg_addr <= `CCS_CFG_LAST);
  wire [15:0] cfg_off = cfg_addr - `CCS_CFG_BASE;

  // flag unit: one arithmetic path shared by add and subtract
  always @* begin
    alu_b_eff    = alu_b;
    alu_cin      = 1'b0;
    alu_res_next = alu_a;
    null_next    = 1'b0;
    nibble_next  = flags_copy_reg[`CCS_NIBBLE_BIT];
    msb_next     = flags_copy_reg[`CCS_MSB_BIT];
    null_upd     = 1'b0;
    carry_upd    = 1'b0;
    msb_upd      = 1'b0;
    // subtract is add of the two's complement
    if (alu_op == `CCS_OP_SUB) begin
      alu_b_eff = ~alu_b; // RQ7
      alu_cin   = 1'b1;   // RQ7
    end
    // nine bits so the carry out of bit 7 is kept
    alu_sum = {1'b0, alu_a} + {1'b0, alu_b_eff} + {8'h00, alu_cin};
    // separate low nibble sum gives the carry out of bit 3
    alu_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b_eff[3:0]} +
              {4'h0, alu_cin};
    case (alu_op)
      // add and subtract set all three result flags
      `CCS_OP_ADD, `CCS_OP_SUB: begin
        alu_res_next = alu_sum[7:0];
        nibble_next  = alu_nib[4];  // RQ5
        msb_next     = alu_sum[8];  // RQ6
        null_upd     = 1'b1;
        carry_upd    = 1'b1;
        msb_upd      = 1'b1;
      end
      // rotate left pulls old msb flag into bit 0
      `CCS_OP_RLC: begin
        alu_res_next = {alu_a[6:0], flags_copy_reg[`CCS_MSB_BIT]};
        msb_next     = alu_a[7];    // RQ8
        msb_upd      = 1'b1;
      end
      // rotate right pulls old msb flag into bit 7
      `CCS_OP_RRC: begin
        alu_res_next = {flags_copy_reg[`CCS_MSB_BIT], alu_a[7:1]};
        msb_next     = alu_a[0];    // RQ8
        msb_upd      = 1'b1;
      end
      // logic result comes ready-made from the core
      `CCS_OP_LOGIC: begin
        alu_res_next = alu_a;
        null_upd     = 1'b1;
      end
      // unknown codes leave the flags alone
      default: begin
        alu_res_next = alu_a;
      end
    endcase
    // zero test on whatever result the operation chose
    null_next = (alu_res_next == 8'h00); // RQ4
  end

  // shadow storage: no reset at all, so contents are undefined
  // after power-on and survive every soft reset untouched
  always @(posedge clk) begin // RQ9
    if (clk_en) begin
      // software writes come first, events may override
      if (wr_flags) begin
        // expiry and sleep bits are read-only to software
        flags_copy_reg[`CCS_NULL_BIT]   <= bus_wdata[`CCS_NULL_BIT];   // RQ1
        flags_copy_reg[`CCS_NIBBLE_BIT] <= bus_wdata[`CCS_NIBBLE_BIT]; // RQ1
        flags_copy_reg[`CCS_MSB_BIT]    <= bus_wdata[`CCS_MSB_BIT];    // RQ1
      end
      // full byte, every bit writable
      if (wr_work) begin
        working_value_copy_reg <= bus_wdata; // RQ10
      end
      // top two bits of the byte are dropped
      if (wr_bank) begin
        bank_select_copy_reg <= bus_wdata[5:0]; // RQ11
      end
      // bit 7 has no storage behind it
      if (wr_pcl) begin
        upper_pc_latch_copy_reg <= bus_wdata[6:0]; // RQ12
      end
      // each pointer byte has its own address
      if (wr_p0lo) begin
        indirect_pointer0_copy_reg[7:0] <= bus_wdata; // RQ14
      end
      // high byte of the first pointer
      if (wr_p0hi) begin
        indirect_pointer0_copy_reg[15:8] <= bus_wdata; // RQ14
      end
      // second pointer, low byte then high byte
      if (wr_p1lo) begin
        indirect_pointer1_copy_reg[7:0] <= bus_wdata; // RQ14
      end
      if (wr_p1hi) begin
        indirect_pointer1_copy_reg[15:8] <= bus_wdata; // RQ14
      end
      // flag unit results
      if (alu_upd) begin
        alu_result_reg <= alu_res_next;
        // zero test for add, subtract and logic
        if (null_upd) begin
          flags_copy_reg[`CCS_NULL_BIT] <= null_next; // RQ4
        end
        // nibble carry only from add and subtract
        if (carry_upd) begin
          flags_copy_reg[`CCS_NIBBLE_BIT] <= nibble_next; // RQ5
        end
        // msb carry, or the bit a rotate pushed out
        if (msb_upd) begin
          flags_copy_reg[`CCS_MSB_BIT] <= msb_next; // RQ6
        end
      end
      // clears are applied before sets so a set never gets lost
      // time-out clears expiry unless a set comes with it
      if (watchdog_timeout) begin
        flags_copy_reg[`CCS_EXPIRY_BIT] <= 1'b0; // RQ2
      end
      // kick and sleep both mark expiry as set
      if (watchdog_kick_instr | sleep_instr) begin
        flags_copy_reg[`CCS_EXPIRY_BIT] <= 1'b1; // RQ2
      end
      // sleep clears the sleep flag
      if (sleep_instr) begin
        flags_copy_reg[`CCS_SLEEP_BIT] <= 1'b0; // RQ3
      end
      // kick sets it again and wins a tie
      if (watchdog_kick_instr) begin
        flags_copy_reg[`CCS_SLEEP_BIT] <= 1'b1; // RQ3
      end
      // interrupt entry captures the whole context last,
      // so it beats any write in the same cycle
      if (isr_entry) begin
        flags_copy_reg             <= core_flags;   // RQ17
        working_value_copy_reg     <= core_work;    // RQ17
        bank_select_copy_reg       <= core_bank;    // RQ17
        upper_pc_latch_copy_reg    <= core_pclatch; // RQ17
        indirect_pointer0_copy_reg <= core_ptr0;    // RQ13
        indirect_pointer1_copy_reg <= core_ptr1;    // RQ13
      end
    end
  end

  // read mux; unimplemented and unmapped bits read as zero
  always @* begin
    rd_data_next = 8'h00;
    case (bus_addr)
      // flags: bits 7:5 have no storage and read zero
      `CCS_FLAGS_ADDR: begin
        rd_data_next = {3'h0, flags_copy_reg}; // RQ1
      end
      `CCS_WORK_ADDR: begin
        rd_data_next = working_value_copy_reg; // RQ10
      end
      // bank select: bits 7:6 read zero
      `CCS_BANK_ADDR: begin
        rd_data_next = {2'h0, bank_select_copy_reg}; // RQ11
      end
      // upper pc latch: bit 7 reads zero
      `CCS_PCLATCH_ADDR: begin
        rd_data_next = {1'b0, upper_pc_latch_copy_reg}; // RQ12
      end
      // pointer bytes, low byte at the lower address
      `CCS_PTR0_LO_ADDR: begin
        rd_data_next = indirect_pointer0_copy_reg[7:0]; // RQ14
      end
      `CCS_PTR0_HI_ADDR: begin
        rd_data_next = indirect_pointer0_copy_reg[15:8]; // RQ14
      end
      `CCS_PTR1_LO_ADDR: begin
        rd_data_next = indirect_pointer1_copy_reg[7:0]; // RQ14
      end
      `CCS_PTR1_HI_ADDR: begin
        rd_data_next = indirect_pointer1_copy_reg[15:8]; // RQ14
      end
      // anything else is unmapped
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // config table: constants only, no write path exists
  always @* begin
    cfg_data_next = 14'h0000;
    if (cfg_hit) begin // RQ15
      case (cfg_off[4:0])
        // sizes of the program array
        `CCS_CFG_ERASE_ROW: begin
          cfg_data_next = `CCS_ERASE_ROW_WORDS; // RQ16
        end
        `CCS_CFG_WR_LATCH: begin
          cfg_data_next = `CCS_WRITE_LATCHES; // RQ16
        end
        `CCS_CFG_USER_ROWS: begin
          cfg_data_next = `CCS_USER_ROWS; // RQ16
        end
        // data eeprom size in bytes
        `CCS_CFG_EE_BYTES: begin
          cfg_data_next = `CCS_EEPROM_BYTES; // RQ16
        end
        // package pin total, fixed per build
        `CCS_CFG_PINS: begin
          cfg_data_next = PIN_COUNT; // RQ16
        end
        // rest of the window is unassigned
        default: begin
          cfg_data_next = 14'h0000;
        end
      endcase
    end
  end

  // control flops: read data and restore pulse
  always @(posedge clk or negedge arst_n) begin
    // power-on reset clears only the pipeline, never a copy
    if (!arst_n) begin
      rd_data_reg  <= `CCS_RD_RESET;
      cfg_data_reg <= 14'h0000;
      restore_reg  <= 1'b0;
    end else if (clk_en) begin
      // soft reset only drops the pulses, never the copies
      if (soft_rst) begin
        rd_data_reg  <= `CCS_RD_RESET;
        cfg_data_reg <= 14'h0000;
        restore_reg  <= 1'b0;
      end else begin
        // read data stands only in the cycle after the strobe
        rd_data_reg  <= bus_rd ? rd_data_next : 8'h00;
        cfg_data_reg <= cfg_rd ? cfg_data_next : 14'h0000;
        // restore strobe one cycle after the return request
        restore_reg  <= isr_return; // RQ17
      end
    end
  end

  // outputs straight from flops
  // the restore bus is the copies themselves, no second register,
  // so a capture shows on it right after the entry edge
  assign bus_rdata       = rd_data_reg;
  assign cfg_rdata       = cfg_data_reg;
  assign restore_strobe  = restore_reg;
  assign restore_flags   = flags_copy_reg;
  assign restore_work    = working_value_copy_reg;
  assign restore_bank    = bank_select_copy_reg;
  assign restore_pclatch = upper_pc_latch_copy_reg;
  assign restore_ptr0    = indirect_pointer0_copy_reg;
  assign restore_ptr1    = indirect_pointer1_copy_reg;
  assign alu_result      = alu_result_reg;

endmodule // ccs_bank

// [sim/ccs_bank_sva.sv]
// assertion checker for the context shadow bank ports
`timescale 1ns/1ps
`include "ccs_defs.vh"

module ccs_bank_sva (
  input logic        clk,
  input logic        arst_n,
  input logic        clk_en,
  input logic        soft_rst,
  input logic [15:0] bus_addr,
  input logic        bus_rd,
  input logic        bus_wr,
  input logic [7:0]  bus_rdata,
  input logic [15:0] cfg_addr,
  input logic        cfg_rd,
  input logic [13:0] cfg_rdata,
  input logic        isr_entry,
  input logic        isr_return,
  input logic [7:0]  core_work,
  input logic [15:0] core_ptr0,
  input logic        restore_strobe,
  input logic [4:0]  restore_flags,
  input logic [7:0]  restore_work,
  input logic [5:0]  restore_bank,
  input logic [15:0] restore_ptr0,
  input logic        watchdog_kick_instr,
  input logic        sleep_instr,
  input logic        watchdog_timeout
);
  // one clock domain, power-on reset disables everything
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // an accepted software read of one address
  sequence s_rd(a);
    clk_en && bus_rd && !soft_rst && bus_addr == a;
  endsequence
  // return accepted, then the core drops it
  sequence s_ret;
    clk_en && isr_return && !soft_rst ##1 !isr_return && clk_en;
  endsequence

  // read data only in the cycle after a read
  a_rdata_idle: assert property (clk_en && !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_work_read: assert property (s_rd(`CCS_WORK_ADDR) |=> bus_rdata == $past(restore_work))
    else $error("working copy read mismatch");
  a_flags_read: assert property (s_rd(`CCS_FLAGS_ADDR) |=>
    bus_rdata == {3'b000, $past(restore_flags)}) else $error("flag copy read mismatch");
  a_bank_read: assert property (s_rd(`CCS_BANK_ADDR) |=>
    bus_rdata == {2'b00, $past(restore_bank)}) else $error("bank copy read mismatch");
  a_ptr_bytes: assert property (s_rd(`CCS_PTR0_HI_ADDR) |=>
    bus_rdata == 8'($past(restore_ptr0) >> 8)) else $error("pointer high byte mismatch");
  a_ctx_capture: assert property (clk_en && isr_entry |=> restore_work == $past(core_work)
    && restore_ptr0 == $past(core_ptr0)) else $error("capture missed core values");
  a_restore_pulse: assert property (s_ret |-> restore_strobe ##1 !restore_strobe)
    else $error("restore pulse wrong");
  a_kick_sets: assert property (clk_en && watchdog_kick_instr && !isr_entry |=>
    restore_flags[4:3] == 2'b11) else $error("kick did not set flags");
  a_sleep_clears: assert property (clk_en && sleep_instr && !watchdog_kick_instr
    && !isr_entry |=> restore_flags[4:3] == 2'b10) else $error("sleep flags wrong");
  a_timeout_clr: assert property (clk_en && watchdog_timeout && !watchdog_kick_instr
    && !sleep_instr && !isr_entry |=> !restore_flags[4]) else $error("expiry not cleared");
  a_cfg_rows: assert property (clk_en && cfg_rd && !soft_rst && cfg_addr == 16'h8202 |=>
    cfg_rdata == 14'h0200) else $error("user row total wrong");
  a_soft_keep: assert property (clk_en && soft_rst && !isr_entry && !bus_wr |=>
    $stable(restore_work)) else $error("soft reset changed a copy");
endmodule // ccs_bank_sva

bind ccs_bank ccs_bank_sva u_sva (.clk, .arst_n, .clk_en, .soft_rst, .bus_addr, .bus_rd, .bus_wr,
  .bus_rdata, .cfg_addr, .cfg_rd, .cfg_rdata, .isr_entry, .isr_return, .core_work, .core_ptr0,
  .restore_strobe, .restore_flags, .restore_work, .restore_bank, .restore_ptr0,
  .watchdog_kick_instr, .sleep_instr, .watchdog_timeout);

// [sim/ccs_bank_tb_top.sv]
// self-checking bench for the context shadow bank
`timescale 1ns/1ps
`include "ccs_defs.vh"

module ccs_bank_tb_top;
  localparam logic [13:0] PINS = 14'h000E;  // small package, differs from the default
  localparam logic [6:0]  EV_ENT = 7'h40, EV_RET = 7'h20, EV_KICK = 7'h10, EV_SLP = 7'h08;
  localparam logic [6:0]  EV_TMO = 7'h04, EV_SRST = 7'h02, EV_ALU = 7'h01;
  // captured values, then after writing all ones
  // expiry captured clear and sleep set, so of the two read-only bits only sleep reads set after writing
  localparam logic [7:0]  CAP [8]  = '{8'h0A, 8'hA5, 8'h2C, 8'h5B, 8'h34, 8'h12, 8'hEF, 8'hBE};
  localparam logic [7:0]  FULL [8] = '{8'h0F, 8'hFF, 8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [13:0] CFG [6]  = '{14'h0020, 14'h0020, 14'h0200, 14'h0100, PINS, 14'h0000};
  // op, a, b, result, null/nibble/msb flags; runs in order, rotates use prior msb flag
  localparam logic [29:0] ALU_T [7] = '{
    {`CCS_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010}, {`CCS_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111},
    {`CCS_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111}, {`CCS_OP_SUB, 8'h00, 8'h01, 8'hFF, 3'b000},
    {`CCS_OP_RLC, 8'h81, 8'h00, 8'h02, 3'b001}, {`CCS_OP_RRC, 8'h01, 8'h00, 8'h80, 3'b001},
    {`CCS_OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b101}};
  logic        clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [6:0]  ev = 7'h00;       // one bit per event pulse
  logic [15:0] bus_addr = 16'h0000, cfg_addr = 16'h0000, core_ptr0 = 16'h0000;
  logic [15:0] core_ptr1 = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00, core_work = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  logic [4:0]  core_flags = 5'h00;
  logic [5:0]  core_bank = 6'h00;
  logic [6:0]  core_pclatch = 7'h00;
  logic [2:0]  alu_op = 3'h0;
  wire         isr_entry, isr_return, watchdog_kick_instr, sleep_instr, watchdog_timeout;
  wire         soft_rst, alu_upd, restore_strobe;
  wire  [7:0]  bus_rdata, restore_work, alu_result;
  wire  [13:0] cfg_rdata;
  wire  [4:0]  restore_flags;
  wire  [5:0]  restore_bank;
  wire  [6:0]  restore_pclatch;
  wire  [15:0] restore_ptr0, restore_ptr1;
  int          failures = 0, check_count = 0;

  assign {isr_entry, isr_return, watchdog_kick_instr, sleep_instr, watchdog_timeout, soft_rst,
          alu_upd} = ev;

  ccs_bank #(.PIN_COUNT(PINS)) dut (.clk, .arst_n, .clk_en, .soft_rst, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .cfg_addr, .cfg_rd, .cfg_rdata, .isr_entry, .isr_return,
    .core_flags, .core_work, .core_bank, .core_pclatch, .core_ptr0, .core_ptr1, .restore_strobe,
    .restore_flags, .restore_work, .restore_bank, .restore_pclatch, .restore_ptr0,
    .restore_ptr1, .watchdog_kick_instr, .sleep_instr, .watchdog_timeout, .alu_upd, .alu_op,
    .alu_a, .alu_b, .alu_result);

  // 25 MHz core clock
  always #20 clk = ~clk;

  // byte-wide and table-word compares
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t table word got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write, strobe dropped at the next edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk8(bus_rdata, exp);
  endtask
  task automatic cfg(input logic [15:0] a, input logic [13:0] exp);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk14(cfg_rdata, exp);
  endtask
  // single-cycle event pulse; returns just after the edge that took it
  task automatic fire(input logic [6:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // copies have no reset value, so capture first
    @(posedge clk);
    {core_flags, core_work, core_bank, core_pclatch} <= {5'h0A, 8'hA5, 6'h2C, 7'h5B};
    {core_ptr0, core_ptr1} <= {16'h1234, 16'hBEEF};
    fire(EV_ENT);
    chk8(restore_work, 8'hA5);
    for (int i = 0; i < 8; i++) rd(`CCS_FLAGS_ADDR + 16'(i), CAP[i]);
    $display("test capture done");
    // all ones everywhere; read-only and unused bits must not follow
    for (int i = 0; i < 8; i++) wr(`CCS_FLAGS_ADDR + 16'(i), 8'hFF);
    for (int i = 0; i < 8; i++) rd(`CCS_FLAGS_ADDR + 16'(i), FULL[i]);
    wr(16'h1FE3, 8'hFF);
    rd(16'h1FE3, 8'h00);
    rd(16'h1FEC, 8'h00);
    wr(`CCS_PTR0_LO_ADDR, 8'h00);
    rd(`CCS_PTR0_HI_ADDR, 8'hFF);
    rd(`CCS_PTR0_LO_ADDR, 8'h00);
    $display("test registers done");
    // power flags: sleep, timeout, then kick beating a timeout
    fire(EV_SLP);
    chk8({6'h00, restore_flags[4:3]}, 8'h02);
    fire(EV_TMO);
    chk8({6'h00, restore_flags[4:3]}, 8'h00);
    fire(EV_TMO | EV_KICK);
    chk8({6'h00, restore_flags[4:3]}, 8'h03);
    fire(EV_SRST);
    rd(`CCS_WORK_ADDR, 8'hFF);
    $display("test flags done");
    foreach (ALU_T[i]) begin
      @(posedge clk);
      {alu_op, alu_a, alu_b} <= ALU_T[i][29:11];
      fire(EV_ALU);
      chk8(alu_result, ALU_T[i][10:3]);
      chk8({5'h00, restore_flags[2:0]}, {5'h00, ALU_T[i][2:0]});
    end
    rd(`CCS_FLAGS_ADDR, 8'h1D);
    $display("test alu done");
    // clk_en low: a write and a sleep event must both be ignored
    @(posedge clk);
    clk_en <= 1'b0;
    wr(`CCS_WORK_ADDR, 8'h00);
    fire(EV_SLP);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(`CCS_WORK_ADDR, 8'hFF);
    rd(`CCS_FLAGS_ADDR, 8'h1D);
    $display("test freeze done");
    wr(`CCS_CFG_BASE, 8'h00);
    for (int i = 0; i < 6; i++) cfg(`CCS_CFG_BASE + 16'(i), CFG[i]);
    cfg(`CCS_CFG_LAST, 14'h0000);
    cfg(16'h8300, 14'h0000);
    $display("test table done");
    // strobe is launched at the edge that takes the return request
    chk8({7'h00, restore_strobe}, 8'h00);
    fire(EV_RET);
    chk8({7'h00, restore_strobe}, 8'h01);
    chk8({1'b0, restore_pclatch}, 8'h7F);
    chk8(restore_ptr1[15:8], 8'hFF);
    chk8(restore_ptr1[7:0], 8'hFF);
    @(posedge clk);
    #1;
    chk8({7'h00, restore_strobe}, 8'h00);
    @(posedge clk);
    #1;
    chk8({7'h00, restore_strobe}, 8'h00);
    $display("test restore done");
    end_sim();
  end
endmodule // ccs_bank_tb_top
